// File: hdl/lc_pkg.sv
// constants for the line-cycle energy and reactive power block
// assumes a 20 MHz master clock and an AXI4-Lite register master

package lc_pkg;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_LINE_ENERGY = 8'h03;
  localparam logic [7:0] IDX_WAVE_SEL = 8'h0D;
  localparam logic [7:0] IDX_NL_CFG = 8'h0E;
  localparam logic [7:0] IDX_ACC_CFG = 8'h0F;
  localparam logic [7:0] IDX_HALF_CYC = 8'h12;
  localparam logic [7:0] IDX_VAR_GAIN = 8'h1E;
  localparam logic [7:0] IDX_VAR_OFS = 8'h21;
  localparam logic [7:0] IDX_IEN_LOW = 8'hD9;
  localparam logic [7:0] IDX_IEN_HIGH = 8'hDB;
  localparam logic [7:0] IDX_IST_LOW = 8'hDC;
  localparam logic [7:0] IDX_IST_HIGH = 8'hDE;

  // ****************************************************************
  // field positions and codes
  // ****************************************************************
  localparam int CYC_END_BIT = 2;
  localparam int WAVE_EN_BIT = 5;
  localparam int SIGN_FLAG_BIT = 4;
  localparam int NOLOAD_FLAG_BIT = 1;
  localparam int SIGN_DIR_BIT = 5;
  localparam int NL_SEL_LSB = 2;
  localparam int WAVE_RATE_LSB = 3;
  localparam logic [2:0] WAVE_SRC_REACTIVE = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // timing and datapath
  // ****************************************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int MAX_RATE_SPS = 25_600;
  localparam logic [12:0] WAVE_DIV = 13'(CLK_HZ / MAX_RATE_SPS);
  localparam logic [2:0] ACC_PERIOD_MCLK = 3'h5;
  localparam int ENERGY_W = 49;
  localparam int LPF_SHIFT = 4;
  localparam int GAIN_FRAC = 12;
  localparam logic signed [13:0] GAIN_ONE = 14'sh1000;
  localparam longint MULT_FS = 64'h4000_0000;
  localparam logic [31:0] NL_THR_1 = 32'(MULT_FS * 15 / 100_000);
  localparam logic [31:0] NL_THR_2 = 32'(MULT_FS * 75 / 1_000_000);
  localparam logic [31:0] NL_THR_3 = 32'(MULT_FS * 37 / 1_000_000);

  typedef enum logic [0:0] {
    LC_WAIT = 1'b0,
    LC_RUN = 1'b1
  } lc_state_t;

endpackage : lc_pkg

// File: hdl/var_lowpass.sv
// first-order low-pass that pulls the dc part out of a power product
// assumes one new product per clock on the same clock

`timescale 1ns/1ps

module var_lowpass (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // data
  input wire logic signed [31:0] i_x,
  output logic signed [31:0] o_y
);

  typedef struct packed {
    logic signed [31:0] y;
  } lp_t;

  lp_t s_r;
  lp_t s_nxt;
  logic signed [32:0] diff;

  // ****************************************************************
  // filter, same pole as the active power filter
  // ****************************************************************
  always_comb
  begin
    s_nxt = s_r;
    diff = 33'(i_x) - 33'(s_r.y);
    s_nxt.y = s_r.y + 32'(diff >>> lc_pkg::LPF_SHIFT);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign o_y = s_r.y;

endmodule : var_lowpass

// File: hdl/line_cycle_energy_and_var_path.sv
// line-cycle active energy and reactive power path with register slave
// assumes zero-crossing pulses, power samples and the 90 degree current
// come from logic on the same clock

`timescale 1ns/1ps

module line_cycle_energy_and_var_path (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  // axi4-lite write
  input wire logic [9:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // axi4-lite read
  input wire logic [9:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // measurement inputs
  input wire logic signed [23:0] I_ACTIVE_POWER,
  input wire logic I_ZERO_CROSS,
  input wire logic signed [15:0] I_VOLTAGE,
  input wire logic signed [15:0] I_CURRENT_90,
  // results
  output logic O_METERING_IRQ,
  output logic O_ACCUM_TICK,
  output logic signed [23:0] O_REACTIVE_POWER,
  output logic O_REACTIVE_ACCUM_EN,
  output logic signed [23:0] O_WAVE_SAMPLE,
  output logic O_WAVE_VALID
);

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_idx;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [23:0] line_energy;
    logic [7:0] wave_sel;
    logic [7:0] nl_cfg;
    logic [7:0] acc_cfg;
    logic [15:0] half_cyc;
    logic [11:0] var_gain;
    logic [15:0] var_ofs;
    logic [7:0] ien_low;
    logic [7:0] ien_high;
    logic [7:0] ist_low;
    logic [7:0] ist_high;
    lc_pkg::lc_state_t lc;
    logic [15:0] hc_cnt;
    logic signed [48:0] acc;
    logic [2:0] tick;
    logic [12:0] wave_cnt;
    logic signed [23:0] wave;
    logic wave_v;
    logic signed [23:0] q_pow;
    logic q_neg;
    logic q_seen;
    logic below;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  logic do_wr;
  logic hc_wr;
  logic cyc_evt;
  logic sign_evt;
  logic below_now;
  logic q_neg_now;
  logic signed [31:0] prod;
  logic signed [31:0] lpf_q;
  logic signed [13:0] gain_fac;
  logic signed [45:0] gained;
  logic signed [33:0] fine;
  logic [31:0] prod_abs;
  logic [31:0] nl_thr;
  logic [12:0] wave_div;
  logic [15:0] hc_next;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic mapped(input logic [7:0] idx);
    logic hit;
    hit = 1'b0;
    if (idx == lc_pkg::IDX_LINE_ENERGY) hit = 1'b1;
    else if (idx == lc_pkg::IDX_WAVE_SEL) hit = 1'b1;
    else if (idx == lc_pkg::IDX_NL_CFG) hit = 1'b1;
    else if (idx == lc_pkg::IDX_ACC_CFG) hit = 1'b1;
    else if (idx == lc_pkg::IDX_HALF_CYC) hit = 1'b1;
    else if (idx == lc_pkg::IDX_VAR_GAIN) hit = 1'b1;
    else if (idx == lc_pkg::IDX_VAR_OFS) hit = 1'b1;
    else if (idx == lc_pkg::IDX_IEN_LOW) hit = 1'b1;
    else if (idx == lc_pkg::IDX_IEN_HIGH) hit = 1'b1;
    else if (idx == lc_pkg::IDX_IST_LOW) hit = 1'b1;
    else if (idx == lc_pkg::IDX_IST_HIGH) hit = 1'b1;
    return hit;
  endfunction : mapped

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] m;
    m = old;
    if (strb[0]) m[7:0] = d[7:0];
    if (strb[1]) m[15:8] = d[15:8];
    return m;
  endfunction : merge16

  // ****************************************************************
  // reactive datapath
  // ****************************************************************
  assign prod = I_VOLTAGE * I_CURRENT_90;
  // the shifter outside already flips for the integrator setting
  assign q_neg_now = fine[33];

  var_lowpass u_lowpass (
    .i_clk(I_SYS_CLK),
    .i_rst_b(I_RST_B),
    .i_x(prod),
    .o_y(lpf_q)
  );

  always_comb
  begin
    gain_fac = lc_pkg::GAIN_ONE + 14'($signed(s_r.var_gain));
    gained = lpf_q * gain_fac;
    // offset lsb is 1/256 of a sample lsb, so samples take bits 31:8
    fine = 34'(gained >>> lc_pkg::GAIN_FRAC) + 34'($signed(s_r.var_ofs));
    prod_abs = prod[31] ? 32'(-prod) : 32'(prod);
    case (s_r.nl_cfg[lc_pkg::NL_SEL_LSB +: 2])
      2'h1: nl_thr = lc_pkg::NL_THR_1;
      2'h2: nl_thr = lc_pkg::NL_THR_2;
      2'h3: nl_thr = lc_pkg::NL_THR_3;
      default: nl_thr = 32'h0;
    endcase
    below_now = prod_abs < nl_thr;
    wave_div = lc_pkg::WAVE_DIV << s_r.wave_sel[lc_pkg::WAVE_RATE_LSB +: 2];
  end

  // ****************************************************************
  // bus handshake terms
  // ****************************************************************
  assign O_AWREADY = !s_r.aw_got && !s_r.bvalid;
  assign O_WREADY = !s_r.w_got && !s_r.bvalid;
  assign O_ARREADY = !s_r.rvalid;
  assign do_wr = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign hc_wr = do_wr && s_r.aw_idx == lc_pkg::IDX_HALF_CYC && |s_r.w_strb[1:0];
  assign hc_next = s_r.hc_cnt + 16'h1;
  assign cyc_evt = s_r.lc == lc_pkg::LC_RUN && I_ZERO_CROSS
                   && hc_next == s_r.half_cyc && !hc_wr;
  assign sign_evt = s_r.q_seen && (q_neg_now != s_r.q_neg)
                    && (s_r.acc_cfg[lc_pkg::SIGN_DIR_BIT] ? s_r.q_neg : q_neg_now);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_nxt = s_r;
    if (I_AWVALID && O_AWREADY)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_idx = I_AWADDR[9:2];
    end
    if (I_WVALID && O_WREADY)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = I_WDATA;
      s_nxt.w_strb = I_WSTRB;
    end
    if (s_r.bvalid && I_BREADY)
      s_nxt.bvalid = 1'b0;
    if (do_wr)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = mapped(s_r.aw_idx) ? lc_pkg::RESP_OKAY : lc_pkg::RESP_SLVERR;
      if (s_r.w_strb[0])
      begin
        if (s_r.aw_idx == lc_pkg::IDX_WAVE_SEL) s_nxt.wave_sel = s_r.w_data[7:0];
        else if (s_r.aw_idx == lc_pkg::IDX_NL_CFG) s_nxt.nl_cfg = s_r.w_data[7:0];
        else if (s_r.aw_idx == lc_pkg::IDX_ACC_CFG) s_nxt.acc_cfg = s_r.w_data[7:0];
        else if (s_r.aw_idx == lc_pkg::IDX_IEN_LOW) s_nxt.ien_low = s_r.w_data[7:0];
        else if (s_r.aw_idx == lc_pkg::IDX_IEN_HIGH) s_nxt.ien_high = s_r.w_data[7:0];
        else if (s_r.aw_idx == lc_pkg::IDX_IST_LOW)
          s_nxt.ist_low = s_r.ist_low & ~s_r.w_data[7:0];
        else if (s_r.aw_idx == lc_pkg::IDX_IST_HIGH)
          s_nxt.ist_high = s_r.ist_high & ~s_r.w_data[7:0];
      end
      if (s_r.aw_idx == lc_pkg::IDX_HALF_CYC)
        s_nxt.half_cyc = merge16(s_r.half_cyc, s_r.w_data, s_r.w_strb);
      else if (s_r.aw_idx == lc_pkg::IDX_VAR_GAIN)
        s_nxt.var_gain = 12'(merge16({4'h0, s_r.var_gain}, s_r.w_data, s_r.w_strb));
      else if (s_r.aw_idx == lc_pkg::IDX_VAR_OFS)
        s_nxt.var_ofs = merge16(s_r.var_ofs, s_r.w_data, s_r.w_strb);
    end

    // read port, one cycle after the address is taken
    if (s_r.rvalid && I_RREADY)
      s_nxt.rvalid = 1'b0;
    if (I_ARVALID && O_ARREADY)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = mapped(I_ARADDR[9:2]) ? lc_pkg::RESP_OKAY : lc_pkg::RESP_SLVERR;
      if (I_ARADDR[9:2] == lc_pkg::IDX_LINE_ENERGY) s_nxt.rdata = {8'h00, s_r.line_energy};
      else if (I_ARADDR[9:2] == lc_pkg::IDX_WAVE_SEL) s_nxt.rdata = {24'h0, s_r.wave_sel};
      else if (I_ARADDR[9:2] == lc_pkg::IDX_NL_CFG) s_nxt.rdata = {24'h0, s_r.nl_cfg};
      else if (I_ARADDR[9:2] == lc_pkg::IDX_ACC_CFG) s_nxt.rdata = {24'h0, s_r.acc_cfg};
      else if (I_ARADDR[9:2] == lc_pkg::IDX_HALF_CYC) s_nxt.rdata = {16'h0, s_r.half_cyc};
      else if (I_ARADDR[9:2] == lc_pkg::IDX_VAR_GAIN) s_nxt.rdata = {20'h0, s_r.var_gain};
      else if (I_ARADDR[9:2] == lc_pkg::IDX_VAR_OFS) s_nxt.rdata = {16'h0, s_r.var_ofs};
      else if (I_ARADDR[9:2] == lc_pkg::IDX_IEN_LOW) s_nxt.rdata = {24'h0, s_r.ien_low};
      else if (I_ARADDR[9:2] == lc_pkg::IDX_IEN_HIGH) s_nxt.rdata = {24'h0, s_r.ien_high};
      else if (I_ARADDR[9:2] == lc_pkg::IDX_IST_LOW) s_nxt.rdata = {24'h0, s_r.ist_low};
      else if (I_ARADDR[9:2] == lc_pkg::IDX_IST_HIGH) s_nxt.rdata = {24'h0, s_r.ist_high};
      else s_nxt.rdata = 32'h0;
    end

    // accumulation strobe
    s_nxt.tick = O_ACCUM_TICK ? 3'h0 : s_r.tick + 3'h1;

    // line-cycle sequencer
    case (s_r.lc)
      lc_pkg::LC_WAIT:
      begin
        // a zero count never starts a period
        if (I_ZERO_CROSS && s_r.half_cyc != 16'h0)
        begin
          s_nxt.lc = lc_pkg::LC_RUN;
          s_nxt.hc_cnt = 16'h0;
          s_nxt.acc = '0;
        end
      end
      lc_pkg::LC_RUN:
      begin
        if (O_ACCUM_TICK)
          s_nxt.acc = s_r.acc + 49'(I_ACTIVE_POWER);
        if (cyc_evt)
        begin
          s_nxt.line_energy = s_nxt.acc[48:25];
          s_nxt.acc = '0;
          s_nxt.hc_cnt = 16'h0;
        end
        else if (I_ZERO_CROSS)
          s_nxt.hc_cnt = hc_next;
      end
      default: s_nxt.lc = lc_pkg::LC_WAIT;
    endcase
    if (hc_wr)
    begin
      s_nxt.lc = lc_pkg::LC_WAIT;
      s_nxt.line_energy = 24'h0;
      s_nxt.acc = '0;
    end

    // reactive result and flags, a set wins over a clear
    s_nxt.q_pow = fine[31:8];
    s_nxt.q_neg = q_neg_now;
    s_nxt.q_seen = 1'b1;
    s_nxt.below = below_now;
    if (cyc_evt)
      s_nxt.ist_high[lc_pkg::CYC_END_BIT] = 1'b1;
    if (sign_evt)
      s_nxt.ist_low[lc_pkg::SIGN_FLAG_BIT] = 1'b1;
    if (below_now)
      s_nxt.ist_low[lc_pkg::NOLOAD_FLAG_BIT] = 1'b1;

    // waveform sampling
    s_nxt.wave_v = 1'b0;
    if (s_r.wave_cnt >= wave_div - 13'h1)
    begin
      s_nxt.wave_cnt = 13'h0;
      if (s_r.ien_high[lc_pkg::WAVE_EN_BIT] && s_r.wave_sel[2:0] == lc_pkg::WAVE_SRC_REACTIVE)
      begin
        s_nxt.wave = s_r.q_pow;
        s_nxt.wave_v = 1'b1;
      end
    end
    else
      s_nxt.wave_cnt = s_r.wave_cnt + 13'h1;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign O_BVALID = s_r.bvalid;
  assign O_BRESP = s_r.bresp;
  assign O_RVALID = s_r.rvalid;
  assign O_RDATA = s_r.rdata;
  assign O_RRESP = s_r.rresp;
  assign O_ACCUM_TICK = s_r.tick == lc_pkg::ACC_PERIOD_MCLK - 3'h1;
  assign O_REACTIVE_POWER = s_r.q_pow;
  assign O_REACTIVE_ACCUM_EN = !s_r.below;
  assign O_WAVE_SAMPLE = s_r.wave;
  assign O_WAVE_VALID = s_r.wave_v;
  // waveform enable shares the high enable register but is no source
  assign O_METERING_IRQ = |(s_r.ist_low & s_r.ien_low)
                          | |(s_r.ist_high & s_r.ien_high
                              & ~(8'h01 << lc_pkg::WAVE_EN_BIT));

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_B);

  chk_cyc_end_set: assert property (cyc_evt |=> s_r.ist_high[2])
    else $error("cycle end did not set its flag");
  chk_irq_pending: assert property (s_r.ist_high[2] && s_r.ien_high[2]
    |-> O_METERING_IRQ)
    else $error("cycle end interrupt not pending");
  chk_period_restart: assert property (cyc_evt |=> s_r.lc == lc_pkg::LC_RUN
    && s_r.hc_cnt == 16'h0)
    else $error("new period did not start at once");
  chk_count_clear: assert property (hc_wr |=> s_r.line_energy == 24'h0
    && s_r.lc == lc_pkg::LC_WAIT)
    else $error("count write did not clear energy");
  chk_count_bound: assert property (s_r.lc == lc_pkg::LC_RUN
    |-> s_r.hc_cnt < s_r.half_cyc)
    else $error("half cycle count passed its limit");
  chk_tick_period: assert property (O_ACCUM_TICK
    |=> !O_ACCUM_TICK [*4] ##1 O_ACCUM_TICK)
    else $error("accumulation strobe not every five clocks");
  chk_sign_dir: assert property (s_r.q_seen && !s_r.q_neg && q_neg_now
    && !s_r.acc_cfg[5] |=> s_r.ist_low[4])
    else $error("falling sign change not flagged");
  chk_noload_flag: assert property (below_now |=> s_r.ist_low[1]
    && !O_REACTIVE_ACCUM_EN)
    else $error("no-load not flagged or not gated");
  chk_wave_rate: assert property (O_WAVE_VALID |=> !O_WAVE_VALID [*8])
    else $error("waveform samples too fast");

endmodule : line_cycle_energy_and_var_path

// File: bench/lc_source_model.sv
// zero-crossing pulse and active power source for the line-cycle bench
// assumes the bench clock and the synchronous active-low reset

`timescale 1ns/1ps

module lc_source_model #(
  parameter int HALF_PERIOD = 200,
  parameter logic signed [23:0] POWER = 24'sh400000
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // source outputs
  output logic o_zero_cross,
  output logic signed [23:0] o_active_power
);
  int cnt;

  // steady power keeps the expected energy exact whatever the phase
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      cnt <= 0;
      o_zero_cross <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == HALF_PERIOD - 1) ? 0 : cnt + 1;
      o_zero_cross <= (cnt == HALF_PERIOD - 1);
    end
  end

  assign o_active_power = POWER;
endmodule : lc_source_model

// File: bench/line_cycle_energy_and_var_path_tb_top.sv
// self-checking bench for the line-cycle energy and reactive path
// assumes a 20 MHz clock and one axi4-lite transfer at a time

`timescale 1ns/1ps

module line_cycle_energy_and_var_path_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [9:0] awaddr = '0;
  logic [9:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, tick, acc_en, wvld, zc;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic signed [23:0] apow, qpow, wsamp;
  logic signed [15:0] volt = 16'h03E8;
  logic signed [15:0] cur = 16'h03E8;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc_n = 0;

  always #25 clk = ~clk;
  always @(posedge clk) cyc_n <= cyc_n + 1;

  lc_source_model u_src (.i_clk(clk), .i_rst_b(rst_b), .o_zero_cross(zc), .o_active_power(apow));

  line_cycle_energy_and_var_path u_dut (
    .I_SYS_CLK(clk), .I_RST_B(rst_b),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_ACTIVE_POWER(apow), .I_ZERO_CROSS(zc), .I_VOLTAGE(volt), .I_CURRENT_90(cur),
    .O_METERING_IRQ(irq), .O_ACCUM_TICK(tick), .O_REACTIVE_POWER(qpow),
    .O_REACTIVE_ACCUM_EN(acc_en), .O_WAVE_SAMPLE(wsamp), .O_WAVE_VALID(wvld));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic tmo;
    n_mismatch++;
    $display("wrong value at %0t: wait ran out", $time);
    results();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // handshakes judged at the negedge before the edge, inputs are steady then
  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_hit, w_hit, b_hit;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge clk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit)
      begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) tmo();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hit, r_hit;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge clk);
      ar_hit = arvalid && arready;
      r_hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit)
      begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) tmo();
  endtask : axi_rd

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(idx, d, r);
    chk({30'h0, r}, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(idx, d, r);
    chk({30'h0, r}, 32'h0);
    chk(d, exp);
  endtask : rd

  // which: 0 interrupt, 1 waveform strobe, 2 accumulation tick
  task automatic await(input int which, input int lim, output int n);
    for (n = 0; n < lim; n++)
    begin
      @(negedge clk);
      if ((which == 0 && irq === 1'b1) || (which == 1 && wvld === 1'b1)
          || (which == 2 && tick === 1'b1)) break;
    end
    if (n == lim) tmo();
  endtask : await

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    rd(lc_pkg::IDX_IST_HIGH, 32'h0);
    axi_rd(8'h50, d, r);
    chk({30'h0, r}, 32'h2);
    axi_wr(8'h51, 32'h1, r);
    chk({30'h0, r}, 32'h2);
    wr(lc_pkg::IDX_LINE_ENERGY, 32'h123);
    rd(lc_pkg::IDX_LINE_ENERGY, 32'h0);
    wr(lc_pkg::IDX_HALF_CYC, 32'hFFFFFFFF);
    rd(lc_pkg::IDX_HALF_CYC, 32'h0000FFFF);
    await(2, 20, n);
    await(2, 20, n);
    chk(32'(n + 1), 32'h5);
  endtask : t_bus

  task automatic t_gain;
    logic [31:0] g [4] = '{32'h0, 32'h800, 32'h400, 32'h0};
    logic [31:0] o [4] = '{32'h0, 32'h0, 32'h0, 32'h100};
    logic [31:0] e [4] = '{32'hF42, 32'h7A1, 32'h1312, 32'hF43};
    cyc(400);
    for (int k = 0; k < 4; k++)
    begin
      wr(lc_pkg::IDX_VAR_GAIN, g[k]);
      wr(lc_pkg::IDX_VAR_OFS, o[k]);
      cyc(10);
      @(negedge clk);
      chk({8'h0, qpow}, e[k]);
    end
    wr(lc_pkg::IDX_VAR_OFS, 32'h0);
  endtask : t_gain

  task automatic t_sign;
    logic signed [15:0] v [4] = '{16'hFC18, 16'h03E8, 16'hFC18, 16'h03E8};
    logic [31:0] dir [4] = '{32'h0, 32'h20, 32'h20, 32'h0};
    logic [31:0] e [4] = '{32'h10, 32'h10, 32'h0, 32'h0};
    wr(lc_pkg::IDX_IEN_LOW, 32'h10);
    for (int k = 0; k < 4; k++)
    begin
      wr(lc_pkg::IDX_ACC_CFG, dir[k]);
      wr(lc_pkg::IDX_IST_LOW, 32'h12);
      volt <= v[k];
      cyc(500);
      rd(lc_pkg::IDX_IST_LOW, e[k]);
      @(negedge clk);
      chk({31'h0, irq}, {31'h0, e[k][4]});
    end
    wr(lc_pkg::IDX_IEN_LOW, 32'h0);
  endtask : t_sign

  // product 60000 lies between the second and third thresholds
  task automatic t_noload;
    logic en;
    volt <= 16'h0258;
    cur <= 16'h0064;
    for (int s = 0; s < 4; s++)
    begin
      en = (s == 0 || s == 3);
      wr(lc_pkg::IDX_NL_CFG, 32'(s << 2));
      wr(lc_pkg::IDX_IST_LOW, 32'h12);
      cyc(3);
      @(negedge clk);
      chk({31'h0, acc_en}, {31'h0, en});
      rd(lc_pkg::IDX_IST_LOW, en ? 32'h0 : 32'h2);
    end
    wr(lc_pkg::IDX_NL_CFG, 32'h0);
    volt <= 16'h03E8;
    cur <= 16'h03E8;
    cyc(400);
  endtask : t_noload

  task automatic t_wave;
    int n;
    wr(lc_pkg::IDX_IEN_HIGH, 32'h20);
    for (int r = 0; r < 4; r++)
    begin
      wr(lc_pkg::IDX_WAVE_SEL, 32'((r << 3) | 4));
      repeat (3) await(1, 7000, n);
      chk(32'(n + 1), 32'(781 << r));
      chk({8'h0, wsamp}, 32'hF42);
    end
    wr(lc_pkg::IDX_IEN_HIGH, 32'h0);
  endtask : t_wave

  // power 2^22 over 80 ticks gives 80*2^22 >> 25 = 10
  task automatic t_line;
    int n;
    int t0;
    wr(lc_pkg::IDX_IEN_HIGH, 32'h4);
    wr(lc_pkg::IDX_HALF_CYC, 32'h2);
    t0 = cyc_n;
    rd(lc_pkg::IDX_LINE_ENERGY, 32'h0);
    await(0, 800, n);
    chk(32'((cyc_n - t0) inside {[395:610]}), 32'h1);
    rd(lc_pkg::IDX_IST_HIGH, 32'h4);
    rd(lc_pkg::IDX_LINE_ENERGY, 32'hA);
    cyc(450);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(lc_pkg::IDX_LINE_ENERGY, 32'hA);
    wr(lc_pkg::IDX_IST_HIGH, 32'h4);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(lc_pkg::IDX_IEN_HIGH, 32'h0);
    cyc(450);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(lc_pkg::IDX_IST_HIGH, 32'h4);
    wr(lc_pkg::IDX_HALF_CYC, 32'h2);
    rd(lc_pkg::IDX_LINE_ENERGY, 32'h0);
    wr(lc_pkg::IDX_IST_HIGH, 32'h4);
    wr(lc_pkg::IDX_IEN_HIGH, 32'h4);
    await(0, 800, n);
    rd(lc_pkg::IDX_LINE_ENERGY, 32'hA);
  endtask : t_line

  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_bus();
    t_gain();
    t_sign();
    t_noload();
    t_wave();
    t_line();
    results();
  end
endmodule : line_cycle_energy_and_var_path_tb_top
